// *** rtcdc_pkg.sv ***
// Package for the divider-chain real time clock: widths, selects, reset values and carriers
package rtcdc_pkg;
	localparam int TMR_W   = 16;            // Reloadable timer width
	localparam int SUB0_W  = 10;            // Lowest sub-timer width
	localparam int SUB1_W  = 6;             // Second sub-timer width
	localparam int SUB2_W  = 6;             // Third sub-timer width
	localparam int SUB3_W  = 10;            // Top sub-timer width
	localparam int CNT_W   = 32;            // Whole count block width
	localparam int NSTG    = 5;             // Timer stages raising requests
	localparam int NSRC    = 4;             // Clock source choices
	localparam int SRC_W   = 2;             // Source select width
	localparam logic [4:0] DIV32_MAX = 5'h1f; // Last state of divide-by-32
	localparam logic [2:0] DIV8_MAX  = 3'h7;  // Last state of divide-by-8
	localparam logic [TMR_W-1:0] TMR_RST = 16'h0000; // Power reset value, timer
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000; // Power reset value, count
	localparam logic [SRC_W-1:0] SRC_RST = 2'h0; // Power reset source select

	// Static configuration carried as one bundle
	typedef struct packed {
		logic [SRC_W-1:0] src_sel;     // Selected clock source
		logic             div32_on;    // Divide-by-32 switched in
		logic             div8_on;     // Divide-by-8 switched in
		logic [TMR_W-1:0] tmr_reload;  // 16-bit timer reload value
		logic [CNT_W-1:0] cnt_reload;  // Packed sub-timer reload values
		logic [NSTG-1:0]  irq_en;      // Per-stage request enables
	} rtcdc_cfg_s;

	// Software write of the count block halves
	typedef struct packed {
		logic             wr_hi;       // Write high half
		logic             wr_lo;       // Write low half
		logic [15:0]      data;        // Write data
	} rtcdc_wr_s;
endpackage

// *** rtcdc_top.sv ***
// Divider-chain real time clock: source pick, prescalers, 16-bit timer, 32-bit count block
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - Chain clocked from one selected source
// RULE2 - Switchable divide-by-32 and divide-by-8 prescalers
// RULE3 - 16-bit reloadable timer follows prescalers
// RULE4 - 32-bit count of 10,6,6,10-bit sub-timers
// RULE5 - Every stage counts upward only
// RULE6 - Each stage raises its own request
// RULE7 - Enabled requests merged into one line
// RULE8 - Only power reset clears the registers; irq_clr also clears the sticky requests
// RULE9 - Overflow reloads and advances next stage
// RULE10 - Request on overflow, forwarded when enabled
module rtcdc_top
	import rtcdc_pkg::*;
(
	input  wire logic              sys_clk,    // System clock, 250 MHz
	input  wire logic              arst_n,     // Power reset, async active low
	input  wire logic [NSRC-1:0]   src_tick,   // Source ticks, internal and pin
	input  wire rtcdc_cfg_s        cfg,        // Software configuration
	input  wire rtcdc_wr_s         wr,         // Count block write port
	input  wire logic              irq_clr,    // Clear all stage requests
	output logic [15:0]            calendar_count_high, // Count bits 31:16
	output logic [15:0]            calendar_count_low,  // Count bits 15:0
	output logic [TMR_W-1:0]       prescale_reload_timer, // 16-bit timer value
	output logic [NSTG-1:0]        stage_req,  // Sticky per-stage requests
	output logic                   rtc_irq     // Shared request line
);
	logic             tick_q;        // Selected source level, registered
	logic [4:0]       div32_q;       // Divide-by-32 state
	logic [2:0]       div8_q;        // Divide-by-8 state
	logic             p32;           // After first prescaler
	logic             p8;            // After second prescaler
	logic [TMR_W-1:0] tmr_q;         // 16-bit timer
	logic [CNT_W-1:0] cnt_q;         // Count block
	logic [CNT_W-1:0] cnt_d;         // Count block after counting, before writes
	logic [NSTG-1:0]  ovf;           // Stage overflow pulses
	logic [4:0]       adv;           // Advance into each timer stage
	logic [NSTG-1:0]  req_q;         // Sticky requests

	localparam int LO [4] = '{0, SUB0_W, SUB0_W+SUB1_W, SUB0_W+SUB1_W+SUB2_W};
	localparam int WD [4] = '{SUB0_W, SUB1_W, SUB2_W, SUB3_W};

	// Source pick, registered so the chain sees one clean enable
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= src_tick[cfg.src_sel]; // [RULE1]
		end
	end

	// Prescalers; bypassed stage passes its input enable straight through
	// A bypassed divider keeps its state, so switching it back in resumes mid-count
	assign p32 = cfg.div32_on ? (tick_q && div32_q == DIV32_MAX) : tick_q; // [RULE2]
	assign p8  = cfg.div8_on ? (p32 && div8_q == DIV8_MAX) : p32; // [RULE2]

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div32_q <= '0;
			div8_q  <= '0;
		end else begin
			if (cfg.div32_on && tick_q) begin
				div32_q <= div32_q + 5'h01; // [RULE2] wraps at 32
			end
			if (cfg.div8_on && p32) begin
				div8_q <= div8_q + 3'h1; // [RULE2] wraps at 8
			end
		end
	end

	// 16-bit timer counts up and reloads on overflow
	assign ovf[0] = p8 && (tmr_q == {TMR_W{1'b1}});
	assign adv[0] = p8;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tmr_q <= TMR_RST; // [RULE8]
		end else if (ovf[0]) begin
			tmr_q <= cfg.tmr_reload; // [RULE3] [RULE9]
		end else if (p8) begin
			tmr_q <= tmr_q + 16'h0001; // [RULE5]
		end
	end

	// Sub-timers: each advances on the overflow of the one below
	// Next values are built per sub-timer so every slice keeps a fixed width
	generate
		for (genvar i = 0; i < 4; i++) begin : g_sub
			assign ovf[i+1] = adv[i+1] && (&cnt_q[LO[i] +: WD[i]]);
			assign adv[i+1] = ovf[i]; // [RULE9]
			// Reload on its own overflow, else step up, else hold
			assign cnt_d[LO[i] +: WD[i]] = ovf[i+1] ? cfg.cnt_reload[LO[i] +: WD[i]] // [RULE4] [RULE9]
				: (adv[i+1] ? cnt_q[LO[i] +: WD[i]] + 1'b1 : cnt_q[LO[i] +: WD[i]]); // [RULE5]
		end
	endgenerate

	// Count block; a software write takes priority over counting
	// A write covers its whole half, so a carry into that half in the same cycle is lost
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= CNT_RST; // [RULE8]
		end else begin
			cnt_q <= cnt_d;
			if (wr.wr_hi) begin
				cnt_q[CNT_W-1 -: CNT_W/2] <= wr.data; // [RULE4]
			end
			if (wr.wr_lo) begin
				cnt_q[CNT_W/2-1:0] <= wr.data; // [RULE4]
			end
		end
	end

	// Sticky requests; a new overflow wins over the clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= '0;
		end else begin
			req_q <= (irq_clr ? '0 : req_q) | ovf; // [RULE6] [RULE10]
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtc_irq               <= 1'b0;
			stage_req             <= '0;
			calendar_count_high   <= '0;
			calendar_count_low    <= '0;
			prescale_reload_timer <= '0;
		end else begin
			rtc_irq               <= |(req_q & cfg.irq_en); // [RULE7] [RULE10]
			stage_req             <= req_q;
			calendar_count_high   <= cnt_q[CNT_W-1 -: CNT_W/2];
			calendar_count_low    <= cnt_q[CNT_W/2-1:0];
			prescale_reload_timer <= tmr_q;
		end
	end

	// Checks on the chain, all on the system clock and off during power reset

	// Selected source line is the one that reaches the chain
	a_src_pick: assert property (@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> tick_q == $past(src_tick[cfg.src_sel])) // [RULE1]
		else $error("wrong source reached the chain");

	// Timer overflow must reload from the reload value next cycle
	a_tmr_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ovf[0] |=> tmr_q == $past(cfg.tmr_reload)) // [RULE9]
		else $error("timer did not reload");

	// Timer moves up by one on an enable without overflow
	a_tmr_up: assert property (@(posedge sys_clk) disable iff (!arst_n)
		p8 && !ovf[0] |=> tmr_q == $past(tmr_q) + 16'h0001) // [RULE5]
		else $error("timer did not step up");

	// Timer holds with no enable
	a_tmr_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!p8 |=> tmr_q == $past(tmr_q)) // [RULE3]
		else $error("timer moved without enable");

	// Timer output register follows the timer one cycle late
	a_tmr_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
		1'b1 |=> prescale_reload_timer == $past(tmr_q)) // [RULE3]
		else $error("timer output stale");

	// Overflow sets its sticky request
	a_req_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ovf[0] |=> req_q[0]) // [RULE6]
		else $error("request not raised");

	// Clear with no overflow empties every request
	a_req_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
		irq_clr && ovf == '0 |=> req_q == '0) // [RULE6]
		else $error("request not cleared");

	sequence s_ovf_en;
		ovf[0] && cfg.irq_en[0];
	endsequence

	// Enabled overflow reaches the shared line in two cycles
	a_irq_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_ovf_en ##1 cfg.irq_en[0] |=> rtc_irq) // [RULE7] [RULE10]
		else $error("shared request missing");

	// Shared line quiet with nothing enabled
	a_irq_mask: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cfg.irq_en == '0 |=> !rtc_irq) // [RULE10]
		else $error("masked request leaked");

	// Lowest sub-timer steps on timer overflow
	a_sub_adv: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ovf[0] && !ovf[1] && !wr.wr_lo |=> cnt_q[SUB0_W-1:0] == $past(cnt_q[SUB0_W-1:0]) + 10'h001) // [RULE4]
		else $error("sub-timer did not advance");

	sequence s_sub0_wrap;
		ovf[1] && !wr.wr_lo;
	endsequence

	// Lowest sub-timer reloads when it wraps
	a_sub_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_sub0_wrap |=> cnt_q[SUB0_W-1:0] == $past(cfg.cnt_reload[SUB0_W-1:0])) // [RULE9]
		else $error("sub-timer did not reload");

	// Count block holds with no advance and no write
	a_cnt_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!ovf[0] && !wr.wr_hi && !wr.wr_lo |=> cnt_q == $past(cnt_q)) // [RULE5]
		else $error("count moved without advance");

	// Bypassed prescalers pass the source tick
	a_bypass: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!cfg.div32_on && !cfg.div8_on |-> p8 == tick_q) // [RULE2]
		else $error("bypass broken");

	// Divide-by-32 fires once per 32 ticks
	a_div32: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cfg.div32_on && p32 |=> div32_q == 5'h00) // [RULE2]
		else $error("prescaler wrap wrong");

	// Divide-by-8 fires once per 8 inputs
	a_div8: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cfg.div8_on && p8 |=> div8_q == 3'h0) // [RULE2]
		else $error("second prescaler wrap wrong");
endmodule

`default_nettype wire

// *** rtc_divider_chain_tb_top.sv ***
// Self-checking bench for the divider-chain real time clock
`timescale 1ns/1ps
`default_nettype none
module rtc_divider_chain_tb_top;
	import rtcdc_pkg::*;
	logic             sys_clk;  // Bench clock
	logic             arst_n;   // Power reset
	logic [NSRC-1:0]  src_tick; // Source ticks
	rtcdc_cfg_s       cfg;      // Configuration
	rtcdc_wr_s        wr;       // Count writes
	logic             irq_clr;  // Request clear
	logic [15:0]      c_hi;     // Count high half
	logic [15:0]      c_lo;     // Count low half
	logic [TMR_W-1:0] tmr;      // Timer value
	logic [NSTG-1:0]  req;      // Sticky requests
	logic             irq;      // Shared request
	int               n_fail;   // Mismatches
	int               n_checks; // Comparisons

	rtcdc_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .src_tick(src_tick), .cfg(cfg), .wr(wr),
		.irq_clr(irq_clr), .calendar_count_high(c_hi), .calendar_count_low(c_lo),
		.prescale_reload_timer(tmr), .stage_req(req), .rtc_irq(irq));

	// Free-running 4 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Inputs always move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One tick per high cycle; four idle cycles cover the output latency
	task automatic ticks(input int sel, input int n);
		src_tick[sel] = 1'b1;
		cyc(n);
		src_tick = '0;
		cyc(4);
	endtask

	// One-cycle write strobe to one half
	task automatic wr_half(input logic hi, input logic [15:0] d);
		wr.wr_hi = hi;
		wr.wr_lo = ~hi;
		wr.data = d;
		cyc(1);
		wr = '0;
		cyc(2);
	endtask

	task automatic test_done();
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Only the selected line advances the timer, always upward
	task automatic t_sources();
		for (int s = 0; s < NSRC; s++) begin
			cfg.src_sel = SRC_W'(s);
			ticks((s + 1) % NSRC, 3);
			ticks(s, s + 1);
			chk("timer by source", 32'((s + 1) * (s + 2) / 2), {16'h0, tmr});
		end
	endtask

	// Two timer steps per pass, each pass starting with the dividers at zero
	task automatic t_prescale();
		int n[3] = '{64, 16, 512};
		cfg.src_sel = '0;
		for (int i = 0; i < 3; i++) begin
			cfg.div32_on = (i != 1);
			cfg.div8_on = (i != 0);
			ticks(0, n[i]);
			chk("timer prescaled", 32'(12 + 2 * i), {16'h0, tmr});
		end
		cfg.div32_on = 1'b0;
		cfg.div8_on = 1'b0;
	endtask

	// Timer wrap reloads, bumps the count and raises a masked request
	task automatic t_overflow();
		cfg.tmr_reload = 16'hfffc;
		ticks(0, 32'h10000 - 16);
		chk("reloaded timer", 32'h0000_fffc, {16'h0, tmr});
		chk("count low", 32'h1, {16'h0, c_lo});
		chk("masked request", 32'h2, {26'h0, req, irq});
		cfg.irq_en = 5'h01;
		cyc(3);
		chk("shared request", 32'h1, {31'h0, irq});
		irq_clr = 1'b1;
		cyc(1);
		irq_clr = 1'b0;
		cyc(3);
		chk("cleared", 32'h0, {26'h0, req, irq});
	endtask

	// Carries ripple through 10, 6, 6 and 10-bit sub-timers
	task automatic t_chain();
		cfg.cnt_reload = 32'h1234_5005;
		wr_half(1'b0, 16'h03ff);
		ticks(0, 4);
		chk("first carry", 32'h0000_0405, {c_hi, c_lo});
		chk("two requests", 32'h03, {27'h0, req});
		wr_half(1'b1, 16'hffff);
		wr_half(1'b0, 16'hffff);
		ticks(0, 4);
		chk("full wrap", 32'h1234_5005, {c_hi, c_lo});
		chk("all requests", 32'h3f, {26'h0, req, irq});
	endtask

	// Power reset held for six cycles, then the scenarios
	initial begin
		n_fail = 0;
		n_checks = 0;
		arst_n = 1'b0;
		src_tick = '0;
		cfg = '0;
		wr = '0;
		irq_clr = 1'b0;
		cyc(6);
		arst_n = 1'b1;
		cyc(2);
		chk("reset state", 32'h0, {c_hi | c_lo | tmr, 10'h0, req, irq});
		t_sources();
		t_prescale();
		t_overflow();
		t_chain();
		test_done();
	end
endmodule
`default_nettype wire
